/* sec_core.v */
// slave command core of a small spi serial eeprom
`include "sec_map.vh"

module sec_core #(
  parameter WR_TIME_NS = `SEC_WR_TIME_NS
) (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire sck_in,
  input  wire cs_n_in,
  input  wire si_in,
  input  wire wp_n_in,
  output reg  so_out,
  output reg  so_oe_out
);

  // rounded down; must stay at least one page long so every byte commits
  localparam [31:0] WR_CYCLES = WR_TIME_NS / `SEC_CLK_NS;
  localparam [31:0] WR_LAST   = WR_CYCLES - 32'h00000001;

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_CMD  = 7'h02;
  localparam [6:0] ST_ADDR = 7'h04;
  localparam [6:0] ST_WDAT = 7'h08;
  localparam [6:0] ST_RDAT = 7'h10;
  localparam [6:0] ST_SRD  = 7'h20;
  localparam [6:0] ST_HOLD = 7'h40;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the link clock is sampled, not used as a clock

  reg        sck_s1_ff, sck_s2_ff, sck_d_ff;
  reg        cs_s1_ff,  cs_s2_ff,  cs_d_ff;
  reg        si_s1_ff,  si_s2_ff;
  reg        wp_s1_ff,  wp_s2_ff;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_d_ff  <= 1'b0;
      cs_s1_ff  <= 1'b1;
      cs_s2_ff  <= 1'b1;
      cs_d_ff   <= 1'b1;
      si_s1_ff  <= 1'b0;
      si_s2_ff  <= 1'b0;
      wp_s1_ff  <= 1'b0;
      wp_s2_ff  <= 1'b0;
    end else begin
      sck_s1_ff <= sck_in;
      sck_s2_ff <= sck_s1_ff;
      sck_d_ff  <= sck_s2_ff;
      cs_s1_ff  <= cs_n_in;
      cs_s2_ff  <= cs_s1_ff;
      cs_d_ff   <= cs_s2_ff;
      si_s1_ff  <= si_in;
      si_s2_ff  <= si_s1_ff;
      wp_s1_ff  <= wp_n_in;
      wp_s2_ff  <= wp_s1_ff;
    end
  end

  wire in_frame = ~cs_s2_ff;
  wire cs_fall  = ~cs_s2_ff & cs_d_ff;
  wire cs_rise  = cs_s2_ff & ~cs_d_ff;
  // idle level of the clock does not matter, which covers both modes
  wire sck_rise = in_frame & sck_s2_ff & ~sck_d_ff;
  wire sck_fall = in_frame & ~sck_s2_ff & sck_d_ff;

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function [7:0] sec_status;
    input [1:0] bp;
    input       write_latch_bit;
    input       rdy;
    begin
      sec_status = {`SEC_ST_ONES, bp, write_latch_bit, rdy};
    end
  endfunction

  function sec_protected;
    input [8:0] a;
    input [1:0] bp;
    begin
      case (bp)
        `SEC_BP_QUARTER: sec_protected = `SEC_IS_4K ? (a >= `SEC_P4_QUARTER)
                                                    : (a[7:0] >= `SEC_P2_QUARTER);
        `SEC_BP_HALF:    sec_protected = `SEC_IS_4K ? (a >= `SEC_P4_HALF)
                                                    : (a[7:0] >= `SEC_P2_HALF);
        `SEC_BP_FULL:    sec_protected = 1'b1;
        default:         sec_protected = 1'b0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // storage: array and page buffer are flip-flops without reset (non-volatile)

  reg  [7:0]  mem_ff [0:`SEC_MEM_DEPTH-1];
  reg  [7:0]  page_buf_ff [0:`SEC_PAGE_BYTES-1];

  reg  [6:0]  state_ff;
  reg  [2:0]  bit_cnt_ff;
  reg  [2:0]  out_cnt_ff;
  reg  [6:0]  in_sh_ff;
  reg  [7:0]  out_sh_ff;
  reg         addr_hi_ff;
  reg         is_rd_ff;
  reg  [8:0]  rd_addr_ff;
  reg  [8:0]  wr_base_ff;
  reg  [4:0]  ptr_ff;
  reg  [31:0] loaded_ff;
  reg         pend_set_ff;
  reg         pend_clr_ff;
  reg         sr_got_ff;
  reg  [1:0]  sr_new_ff;
  reg         abort_ff;
  reg         wel_ff;
  reg  [1:0]  bp_ff;
  reg         busy_ff;
  reg  [31:0] wr_cnt_ff;
  reg  [3:0]  page_ff;

  wire [7:0]  in_byte   = {in_sh_ff, si_s2_ff};
  wire        byte_done = sck_rise & (bit_cnt_ff == `SEC_BIT_LAST);
  wire [8:0]  addr_full = {addr_hi_ff & `SEC_IS_4K, in_byte};
  wire [8:0]  rd_sum    = rd_addr_ff + 9'h001;
  wire [8:0]  rd_next   = {rd_sum[8] & `SEC_IS_4K, rd_sum[7:0]};
  wire [4:0]  cm_idx    = wr_cnt_ff[4:0];
  wire [8:0]  cm_addr   = {page_ff, cm_idx};
  wire        cm_en     = busy_ff & (wr_cnt_ff < `SEC_PAGE_CNT) & loaded_ff[cm_idx]
                          & ~sec_protected(cm_addr, bp_ff);
  wire        wr_ok     = wel_ff & wp_s2_ff & ~abort_ff;

  always @(posedge clk_in) begin
    if (cm_en) begin
      mem_ff[cm_addr] <= page_buf_ff[cm_idx];
    end
    if ((state_ff == ST_WDAT) && byte_done) begin
      page_buf_ff[ptr_ff] <= in_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= `SEC_BIT_ZERO;
      out_cnt_ff  <= `SEC_BIT_ZERO;
      in_sh_ff    <= 7'h00;
      out_sh_ff   <= 8'h00;
      addr_hi_ff  <= 1'b0;
      is_rd_ff    <= 1'b0;
      rd_addr_ff  <= 9'h000;
      wr_base_ff  <= 9'h000;
      ptr_ff      <= 5'h00;
      loaded_ff   <= 32'h00000000;
      pend_set_ff <= 1'b0;
      pend_clr_ff <= 1'b0;
      sr_got_ff   <= 1'b0;
      sr_new_ff   <= 2'h0;
      abort_ff    <= 1'b0;
      wel_ff      <= 1'b0;
      bp_ff       <= 2'h0;
      busy_ff     <= 1'b0;
      wr_cnt_ff   <= 32'h00000000;
      page_ff     <= 4'h0;
      so_out      <= 1'b0;
      so_oe_out   <= 1'b0;
    end else begin
      if (cs_fall) begin
        state_ff    <= ST_CMD;
        bit_cnt_ff  <= `SEC_BIT_ZERO;
        out_cnt_ff  <= `SEC_BIT_ZERO;
        pend_set_ff <= 1'b0;
        pend_clr_ff <= 1'b0;
        sr_got_ff   <= 1'b0;
        abort_ff    <= 1'b0;
        addr_hi_ff  <= 1'b0; // a stale flag would pass later bytes off as a status write
        so_oe_out   <= 1'b1;
      end else if (cs_rise) begin
        state_ff  <= ST_IDLE;
        so_oe_out <= 1'b0;
        // partial bytes simply never reach any of the actions below
        if (pend_set_ff) begin
          wel_ff <= 1'b1;
        end else if (pend_clr_ff) begin
          wel_ff <= 1'b0;
        end
        if ((state_ff == ST_WDAT) && wr_ok && (|loaded_ff)) begin
          busy_ff   <= 1'b1;
          wr_cnt_ff <= 32'h00000000;
          page_ff   <= wr_base_ff[8:5];
        end else if ((state_ff == ST_HOLD) && sr_got_ff && wr_ok) begin
          bp_ff     <= sr_new_ff;
          busy_ff   <= 1'b1;
          wr_cnt_ff <= 32'h00000000;
        end
      end else if (in_frame) begin
        if (~wp_s2_ff) begin
          abort_ff <= 1'b1;
        end
        if (sck_rise) begin
          in_sh_ff   <= in_byte[6:0];
          bit_cnt_ff <= bit_cnt_ff + `SEC_BIT_ONE;
        end
        if (byte_done) begin
          case (state_ff)
            ST_CMD: begin
              if (busy_ff && (in_byte != `SEC_OP_STAT_RD)) begin
                state_ff <= ST_HOLD;
              end else if (in_byte == `SEC_OP_STAT_RD) begin
                state_ff  <= ST_SRD;
                out_sh_ff <= sec_status(bp_ff, wel_ff, busy_ff);
              end else if (in_byte == `SEC_OP_SET_LATCH) begin
                pend_set_ff <= 1'b1;
                state_ff    <= ST_HOLD;
              end else if (in_byte == `SEC_OP_CLR_LATCH) begin
                pend_clr_ff <= 1'b1;
                state_ff    <= ST_HOLD;
              end else if (in_byte == `SEC_OP_STAT_WR) begin
                state_ff  <= ST_HOLD;
                sr_got_ff <= 1'b0;
                loaded_ff <= 32'h00000000;
                is_rd_ff  <= 1'b0;
                addr_hi_ff <= 1'b1;
              end else if ((in_byte[7:4] == `SEC_OP_HI_ZERO) &&
                           ((in_byte[2:0] == `SEC_OP_ARR_RD) ||
                            (in_byte[2:0] == `SEC_OP_ARR_WR))) begin
                state_ff   <= ST_ADDR;
                is_rd_ff   <= (in_byte[2:0] == `SEC_OP_ARR_RD);
                addr_hi_ff <= in_byte[`SEC_OP_ABH_POS];
              end else begin
                state_ff <= ST_HOLD;
              end
            end
            ST_ADDR: begin
              if (is_rd_ff) begin
                state_ff   <= ST_RDAT;
                out_sh_ff  <= mem_ff[addr_full];
                rd_addr_ff <= addr_full;
              end else begin
                state_ff   <= ST_WDAT;
                wr_base_ff <= addr_full;
                ptr_ff     <= in_byte[4:0];
                loaded_ff  <= 32'h00000000;
              end
            end
            ST_WDAT: begin
              loaded_ff[ptr_ff] <= 1'b1;
              ptr_ff            <= ptr_ff + 5'h01;
            end
            ST_HOLD: begin
              // only the first byte after a status write opcode counts
              if (~sr_got_ff && ~is_rd_ff && addr_hi_ff && ~pend_set_ff && ~pend_clr_ff) begin
                sr_got_ff <= 1'b1;
                sr_new_ff <= in_byte[`SEC_ST_BP_HI:`SEC_ST_BP_LO];
                addr_hi_ff <= 1'b0;
              end
            end
            default: begin
              state_ff <= state_ff;
            end
          endcase
        end
        if (sck_fall && ((state_ff == ST_RDAT) || (state_ff == ST_SRD))) begin
          so_out     <= out_sh_ff[7];
          out_cnt_ff <= out_cnt_ff + `SEC_BIT_ONE;
          if (out_cnt_ff == `SEC_BIT_LAST) begin
            if (state_ff == ST_RDAT) begin
              out_sh_ff  <= mem_ff[rd_next];
              rd_addr_ff <= rd_next;
            end else begin
              out_sh_ff <= sec_status(bp_ff, wel_ff, busy_ff);
            end
          end else begin
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
          end
        end
      end
      if (busy_ff) begin
        wr_cnt_ff <= wr_cnt_ff + 32'h00000001;
        if (wr_cnt_ff == WR_LAST) begin
          busy_ff   <= 1'b0;
          wel_ff    <= 1'b0;
          loaded_ff <= 32'h00000000;
        end
      end
    end
  end

endmodule // sec_core

/* sec_map.vh */
// constants for the serial eeprom command core
`ifndef SEC_MAP_VH
`define SEC_MAP_VH

// instruction codes
`define SEC_OP_SET_LATCH  8'h06
`define SEC_OP_CLR_LATCH  8'h04
`define SEC_OP_STAT_RD    8'h05
`define SEC_OP_STAT_WR    8'h01
`define SEC_OP_HI_ZERO    4'h0
`define SEC_OP_ARR_RD     3'h3
`define SEC_OP_ARR_WR     3'h2
`define SEC_OP_ABH_POS    3

// status_control layout
`define SEC_ST_RDY        0
`define SEC_ST_WEL        1
`define SEC_ST_BP_LO      2
`define SEC_ST_BP_HI      3
`define SEC_ST_ONES       4'hF

// array geometry; SEC_IS_4K selects the 4-Kbit part (0 for the 2-Kbit part)
`define SEC_IS_4K         1'b1
`define SEC_ADDR_W        9
`define SEC_MEM_DEPTH     512
`define SEC_PAGE_W        5
`define SEC_PAGE_BYTES    32
`define SEC_PAGE_CNT      32'h00000020

// protected range bases per block-protect code
`define SEC_BP_NONE       2'h0
`define SEC_BP_QUARTER    2'h1
`define SEC_BP_HALF       2'h2
`define SEC_BP_FULL       2'h3
`define SEC_P4_QUARTER    9'h180
`define SEC_P4_HALF       9'h100
`define SEC_P2_QUARTER    8'hC0
`define SEC_P2_HALF       8'h80

// serial framing
`define SEC_BIT_LAST      3'h7
`define SEC_BIT_ZERO      3'h0
`define SEC_BIT_ONE       3'h1

// timing
`define SEC_CLK_NS        10
`define SEC_WR_TIME_NS    5000000

`endif

/* sec_core_props.sv */
// checker on the serial pins of the eeprom command core
module sec_core_props #(
  parameter WR_TIME_NS = 2000
) (
  input logic clk_in,
  input logic rst_n_in,
  input logic sck_in,
  input logic cs_n_in,
  input logic si_in,
  input logic wp_n_in,
  input logic so_out,
  input logic so_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  //////////////////////////////////////////////////////////////////////////////
  chk_oe_off_idle: assert property (cs_n_in [*5] |-> !so_oe_out)
    else $error("so driven while deselected");
  chk_oe_on_sel: assert property (!cs_n_in [*5] |-> so_oe_out)
    else $error("so not driven while selected");
  chk_oe_rise_sel: assert property ($rose(so_oe_out) |-> !$past(cs_n_in, 2))
    else $error("so enable rose without select");
  chk_oe_fall_desel: assert property ($fell(so_oe_out) |-> $past(cs_n_in, 2))
    else $error("so enable fell while selected");
  chk_oe_drop_time: assert property ($rose(cs_n_in) |-> ##[2:5] !so_oe_out)
    else $error("so enable late to release");
  chk_oe_up_time: assert property ($fell(cs_n_in) |-> ##[2:5] so_oe_out)
    else $error("so enable late to drive");
  // sck high six samples means the last fall has long been served
  chk_so_hold_high: assert property ((!cs_n_in && sck_in && so_oe_out) [*6]
    |-> $stable(so_out)) else $error("so moved while sck high");
  chk_so_fall_cause: assert property (($changed(so_out) && so_oe_out && $past(so_oe_out))
    |-> (!$past(sck_in, 2) || !$past(sck_in, 3) || !$past(sck_in, 4)))
    else $error("so moved without a sck fall");
endmodule // sec_core_props

bind sec_core sec_core_props #(.WR_TIME_NS(WR_TIME_NS)) i_sec_core_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
  .si_in(si_in), .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_out(so_oe_out));

/* sec_host.sv */
// spi host model driving the eeprom core pins
module sec_host (
  input  wire logic clk_in,
  input  wire logic so_in,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  output logic      wp_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:7];
  logic       cpol = 1'b0;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    wp_n_out = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one frame of msb-first bits; cs always rises at its end
  task automatic run(input int nb, input int wp_at);
    @(posedge clk_in);
    #1 sck_out = cpol; // idle level, mode (0,0) or (1,1)
    #50 cs_n_out = 1'b0;
    for (int b = 0; b < nb; b++) begin
      wp_n_out = (b == wp_at) ? 1'b0 : wp_n_out;
      sck_out = 1'b0;
      si_out = tx[b/8][7-b%8];
      #62.5 sck_out = 1'b1;
      rx[b/8][7-b%8] = so_in;
      #62.5;
    end
    sck_out = cpol;
    #62.5 cs_n_out = 1'b1;
    si_out = ~si_out; // no stale level once released
    wp_n_out = 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
endmodule // sec_host

/* test_sec_core.sv */
// self-checking bench for the serial eeprom command core
`include "sec_map.vh"
module test_sec_core;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR_NS = 20000;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  wire        sck, cs_n, si, wp_n, so_out, so_oe_out;
  wire        so = so_oe_out ? so_out : 1'bz;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cyc = 0;
  logic [7:0] d [0:4];
  logic [7:0] v;
  sec_core #(.WR_TIME_NS(WR_NS)) i_sec_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n), .so_out(so_out),
    .so_oe_out(so_oe_out));
  sec_host i_sec_host (.clk_in(clk_in), .so_in(so), .sck_out(sck), .cs_n_out(cs_n),
    .si_out(si), .wp_n_out(wp_n));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] stat(input logic [1:0] bp, input logic write_latch_bit, input logic rdy);
    return {`SEC_ST_ONES, bp, write_latch_bit, rdy};
  endfunction
  task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, input int nb, input int wp);
    i_sec_host.tx[0] = b0;
    i_sec_host.tx[1] = b1;
    for (int i = 0; i < 5; i++) i_sec_host.tx[i+2] = d[i];
    i_sec_host.run(nb, wp);
  endtask
  task automatic cmd(input logic [7:0] op);
    xfer(op, 8'h00, 8, -1);
  endtask
  task automatic st_chk(input logic [7:0] exp);
    xfer(`SEC_OP_STAT_RD, 8'h00, 16, -1);
    check8(i_sec_host.rx[1], exp);
  endtask
  task automatic wr(input logic [8:0] a, input int n, input int wp);
    xfer({`SEC_OP_HI_ZERO, a[8], `SEC_OP_ARR_WR}, a[7:0], 16 + 8 * n, wp);
  endtask
  task automatic rd1(input logic [8:0] a, input logic [7:0] exp);
    xfer({`SEC_OP_HI_ZERO, a[8], `SEC_OP_ARR_RD}, a[7:0], 24, -1);
    check8(i_sec_host.rx[2], exp);
  endtask
  // polling is bounded; a stuck busy shows in the next status or read compare
  task automatic wait_rdy();
    int k = 0;
    do begin
      xfer(`SEC_OP_STAT_RD, 8'h00, 16, -1);
      k++;
    end while (k < 30 && i_sec_host.rx[1][`SEC_ST_RDY] !== 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(61535));
    repeat (20) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    st_chk(stat(2'h0, 1'b0, 1'b0));
    i_sec_host.cpol = 1'b1;
    cmd(`SEC_OP_SET_LATCH);
    st_chk(stat(2'h0, 1'b1, 1'b0));
    i_sec_host.cpol = 1'b0;
    cmd(`SEC_OP_CLR_LATCH);
    st_chk(stat(2'h0, 1'b0, 1'b0));
    xfer(`SEC_OP_SET_LATCH, 8'h00, 5, -1);
    st_chk(stat(2'h0, 1'b0, 1'b0));
    cmd(`SEC_OP_SET_LATCH);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h0C : (i == 1) ? 8'h0E : (i == 2) ? 8'h00 : (8'($urandom) | 8'h10);
      cmd(v);
      st_chk(stat(2'h0, 1'b1, 1'b0));
    end
    $display("test latch and decode done");
    foreach (d[i]) d[i] = 8'($urandom);
    wr(9'h1FC, 5, -1);
    st_chk(stat(2'h0, 1'b1, 1'b1));
    cmd(`SEC_OP_CLR_LATCH);
    st_chk(stat(2'h0, 1'b1, 1'b1));
    wait_rdy();
    st_chk(stat(2'h0, 1'b0, 1'b0));
    xfer({`SEC_OP_HI_ZERO, 1'b1, `SEC_OP_ARR_RD}, 8'hFC, 48, -1);
    for (int i = 0; i < 4; i++) check8(i_sec_host.rx[i+2], d[i]);
    rd1(9'h1E0, d[4]);
    v = d[4];
    d[0] = ~v;
    wr(9'h1E0, 1, -1);
    wait_rdy();
    rd1(9'h1E0, v);
    $display("test page write done");
    cmd(`SEC_OP_SET_LATCH);
    xfer(`SEC_OP_STAT_WR, 8'hF7, 16, -1);
    wait_rdy();
    st_chk(stat(2'h1, 1'b0, 1'b0));
    cmd(`SEC_OP_SET_LATCH);
    wr(9'h1E0, 1, -1);
    xfer(`SEC_OP_STAT_WR, 8'hFF, 16, -1);
    wait_rdy();
    st_chk(stat(2'h1, 1'b0, 1'b0));
    rd1(9'h1E0, v);
    cmd(`SEC_OP_SET_LATCH);
    d[0] = 8'($urandom);
    wr(9'h17F, 1, -1);
    wait_rdy();
    rd1(9'h17F, d[0]);
    $display("test protection done");
    v = d[0];
    d[0] = ~v;
    cmd(`SEC_OP_SET_LATCH);
    wr(9'h17F, 1, 20);
    wait_rdy();
    rd1(9'h17F, v);
    $display("test write protect done");
    report_and_stop();
  end
endmodule // test_sec_core
